// file: hdl/tam_pkg.sv
package tam_pkg;
  // System clock and the 10 ms timing base.
  localparam int unsigned CLK_HZ      = 50_000_000;
  localparam int unsigned TICK_MS     = 10;
  localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned TICK_W      = 19;
  // Input counts and field widths.
  localparam int unsigned N_AIN = 4;
  localparam int unsigned N_DIN = 4;
  localparam int unsigned N_CH  = N_AIN + N_DIN;
  localparam int unsigned THR_W = 10;
  localparam int unsigned VAL_W = 8;
  localparam int unsigned REP_W = 10;
  localparam int unsigned ID_W  = 8;
  localparam int unsigned SRC_W = 3;
  // Fixed rate of the master's secondary port.
  localparam int unsigned SEC_BAUD  = 19200;
  localparam int unsigned SEC_DIV_W = 12;
  localparam logic [SEC_DIV_W-1:0] SEC_DIV =
    SEC_DIV_W'(CLK_HZ / SEC_BAUD);
  // Reset values.
  localparam logic [ID_W-1:0]  ID_NONE  = 8'h00;
  localparam logic [VAL_W-1:0] VAL_ZERO = 8'h00;
  localparam logic [REP_W-1:0] REP_ZERO = 10'h000;
  localparam logic [REP_W-1:0] REP_ONE  = 10'h001;

  // Station roles.
  typedef enum logic [2:0] {
    TAM_ONE_WAY_MIRROR_MASTER     = 3'b000,
    TAM_ONE_WAY_MIRROR_OUTSTATION = 3'b001,
    TAM_TWO_WAY_MIRROR_MASTER     = 3'b010,
    TAM_TWO_WAY_MIRROR_OUTSTATION = 3'b011,
    TAM_MULTI_OUTSTATION_MASTER   = 3'b100,
    TAM_MULTI_OUTSTATION          = 3'b101,
    TAM_COMBINED_POLLED_MASTER    = 3'b110,
    TAM_COMBINED_OUTSTATION       = 3'b111
  } tam_mode_t;

  // Alarm message sender states.
  typedef enum logic [1:0] {
    TAM_IDLE = 2'b00,
    TAM_SEND = 2'b01,
    TAM_GAP  = 2'b10
  } tam_snd_t;
endpackage

// file: hdl/tam_val_if.sv
`timescale 1ns/1ps
interface tam_val_if;
  import tam_pkg::*;
  logic                       tick;
  logic [N_CH-1:0]            cond;
  logic [N_CH-1:0][VAL_W-1:0] period;
  logic [N_CH-1:0]            alarm;
  modport src (output tick, output cond, output period, input alarm);
  modport val (input tick, input cond, input period, output alarm);
endinterface

// file: hdl/tam_validator.sv
`timescale 1ns/1ps
module tam_validator (
  input  wire logic clk_i,   // System clock.
  input  wire logic rst_n_i, // Synchronous reset, active low.
  tam_val_if.val    vif      // Conditions in, validated alarms out.
);
  import tam_pkg::*;

  logic [N_CH-1:0][VAL_W-1:0] cnt_q;
  logic [N_CH-1:0]            alarm_q;

  assign vif.alarm = alarm_q;

  // One persistence counter per input; a period of 0 acts as 1.
  for (genvar i = 0; i < N_CH; i++) begin : g_ch
    always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
        cnt_q[i]   <= VAL_ZERO;
        alarm_q[i] <= 1'b0;
      end else if (!vif.cond[i]) begin
        cnt_q[i]   <= VAL_ZERO;
        alarm_q[i] <= 1'b0;
      end else if (vif.tick && !alarm_q[i]) begin
        cnt_q[i] <= cnt_q[i] + 8'h01;
        if (cnt_q[i] + 8'h01 >= vif.period[i]) begin
          alarm_q[i] <= 1'b1;
        end
      end
    end

    property p_clear_restarts;
      @(posedge clk_i) disable iff (!rst_n_i)
      !vif.cond[i] |=> (cnt_q[i] == VAL_ZERO) && !alarm_q[i];
    endproperty
    a_clear_restarts: assert property (p_clear_restarts)
      else $error("Validation did not restart after condition cleared.");

    sequence s_held_to_period;
      vif.cond[i] && vif.tick && (cnt_q[i] + 8'h01 >= vif.period[i]);
    endsequence
    property p_declare_on_period;
      @(posedge clk_i) disable iff (!rst_n_i)
      $rose(alarm_q[i]) |-> $past(vif.cond[i]) && $past(vif.tick);
    endproperty
    a_declare_on_period: assert property (p_declare_on_period)
      else $error("Alarm declared without a full validation period.");
    property p_declare_follows;
      @(posedge clk_i) disable iff (!rst_n_i)
      (!alarm_q[i] ##0 s_held_to_period) |=> alarm_q[i];
    endproperty
    a_declare_follows: assert property (p_declare_follows)
      else $error("Alarm not declared when validation period ended.");
  end
endmodule

// file: hdl/tam_monitor.sv
`timescale 1ns/1ps
module tam_monitor #(
  parameter int unsigned TICK_CYC = tam_pkg::TICK_CYCLES // Cycles per tick.
) (
  input  wire logic                      clk_i,          // System clock.
  input  wire logic                      rst_n_i,        // Sync reset, low.
  input  wire tam_pkg::tam_mode_t        mode_i,         // Station role.
  input  wire logic [tam_pkg::ID_W-1:0]  station_id_i,   // Own ID.
  input  wire logic                      oneway_i,       // No acknowledge.
  input  wire logic [3:0][9:0]           ain_value_i,    // Converted values.
  input  wire logic [3:0][9:0]           ain_thr_i,      // Thresholds.
  input  wire logic [3:0]                ain_below_i,    // Alarm when below.
  input  wire logic [3:0]                din_i,          // Digital inputs.
  input  wire logic [3:0]                din_en_i,       // Alarm enables.
  input  wire logic [3:0]                din_fall_i,     // High-to-low edge.
  input  wire logic [7:0][7:0]           val_period_i,   // Periods, ticks.
  input  wire logic [9:0]                repeat_i,       // Repeat, ticks.
  input  wire logic [9:0]                retry_i,        // Sends per alarm.
  input  wire logic                      poll_req_i,     // Master poll.
  input  wire logic [tam_pkg::ID_W-1:0]  poll_id_i,      // ID to poll.
  input  wire logic                      rx_valid_i,     // Link frame in.
  input  wire logic                      rx_poll_i,      // Frame is a poll.
  input  wire logic [tam_pkg::ID_W-1:0]  rx_id_i,        // Frame ID.
  input  wire logic [3:0]                rx_din_i,       // Remote inputs.
  input  wire logic                      rx_alarm_i,     // Frame has alarm.
  input  wire logic [7:0]                rx_data_i,      // Frame payload.
  input  wire logic                      rx_data_vld_i,  // Payload is data.
  output logic [7:0]                     alarm_o,        // Valid alarms.
  output logic                           msg_valid_o,    // Alarm message.
  output logic [tam_pkg::SRC_W-1:0]      msg_src_o,      // Alarm input.
  output logic [tam_pkg::ID_W-1:0]       msg_id_o,       // Sender ID.
  output logic                           tx_state_vld_o, // Send inputs.
  output logic [3:0]                     tx_din_o,       // Inputs sent.
  output logic                           poll_vld_o,     // Poll frame.
  output logic [tam_pkg::ID_W-1:0]       poll_id_o,      // Polled ID.
  output logic [3:0]                     dout_o,         // Mirror outputs.
  output logic                           main_vld_o,     // Main port.
  output logic [7:0]                     main_data_o,    // Main data.
  output logic                           sec_vld_o,      // Secondary port.
  output logic [7:0]                     sec_data_o,     // Secondary data.
  output logic [tam_pkg::SEC_DIV_W-1:0]  sec_div_o,      // Baud divider.
  output logic                           tick_o          // 10 ms tick.
);
  import tam_pkg::*;

  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYC - 1);
  tam_val_if vif ();
  logic [TICK_W-1:0]          tick_cnt_q;
  logic                       tick_q;
  logic [3:0]                 din_q;
  logic [3:0]                 armed_q;
  logic [3:0]                 ain_cond;
  logic [N_CH-1:0]            alarm_q;
  logic [N_CH-1:0]            rise;
  logic [N_CH-1:0]            rep_hit;
  logic [N_CH-1:0][REP_W-1:0] rep_cnt_q;
  logic [N_CH-1:0]            pend_q;
  logic [N_CH-1:0]            take;
  tam_snd_t                   snd_q;
  logic [SRC_W-1:0]           cur_q;
  logic [REP_W-1:0]           left_q;
  logic [SRC_W-1:0]           pick;
  logic                       any_pend;
  logic                       addressed;

  // Lowest-numbered pending input wins the sender.
  function automatic logic [SRC_W-1:0] first_set(input logic [N_CH-1:0] v);
    logic [SRC_W-1:0] r;
    r = '0;
    for (int k = N_CH - 1; k >= 0; k--) begin
      if (v[k]) begin
        r = SRC_W'(k);
      end
    end
    return r;
  endfunction

  // Single 10 ms tick; a parameter lets simulation shorten it.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      tick_cnt_q <= '0;
      tick_q     <= 1'b0;
    end else if (tick_cnt_q == TICK_LAST) begin
      tick_cnt_q <= '0;
      tick_q     <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + 19'h0_0001;
      tick_q     <= 1'b0;
    end
  end

  // Analogue conditions; a zero threshold never alarms.
  always_comb begin
    for (int k = 0; k < N_AIN; k++) begin
      ain_cond[k] = (ain_thr_i[k] != 10'h000) &&
        (ain_below_i[k] ? (ain_value_i[k] < ain_thr_i[k])
                        : (ain_value_i[k] > ain_thr_i[k]));
    end
  end

  // Digital conditions are armed by the chosen edge and last while the
  // input stays at its new level, so the edge itself can be validated.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      din_q   <= 4'h0;
      armed_q <= 4'h0;
    end else begin
      din_q <= din_i;
      for (int k = 0; k < N_DIN; k++) begin
        if (!din_en_i[k] || (din_i[k] == din_fall_i[k])) begin
          armed_q[k] <= 1'b0;
        end else if (din_q[k] == din_fall_i[k]) begin
          armed_q[k] <= 1'b1;
        end
      end
    end
  end

  assign vif.tick   = tick_q;
  assign vif.cond   = {armed_q, ain_cond};
  assign vif.period = val_period_i;
  tam_validator u_val (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .vif     (vif)
  );
  assign rise = vif.alarm & ~alarm_q;
  // Repeat timers run while each alarm holds; zero interval never fires.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      alarm_q   <= '0;
      rep_cnt_q <= '0;
    end else begin
      alarm_q <= vif.alarm;
      for (int k = 0; k < N_CH; k++) begin
        if (!vif.alarm[k] || rise[k] || rep_hit[k]) begin
          rep_cnt_q[k] <= REP_ZERO;
        end else if (tick_q) begin
          rep_cnt_q[k] <= rep_cnt_q[k] + REP_ONE;
        end
      end
    end
  end
  // A repeat fires on the tick that completes the interval.
  always_comb begin
    for (int k = 0; k < N_CH; k++) begin
      rep_hit[k] = vif.alarm[k] && !rise[k] && tick_q &&
                   (repeat_i != REP_ZERO) &&
                   (rep_cnt_q[k] + REP_ONE >= repeat_i);
    end
  end

  assign any_pend = |pend_q;
  assign pick     = first_set(pend_q);
  assign take     = (snd_q == TAM_IDLE && any_pend)
                    ? (N_CH'(1) << pick) : '0;

  // Pending flags: a new onset or repeat wins over the sender's clear.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      pend_q <= '0;
    end else begin
      pend_q <= (pend_q & ~take) | rise | rep_hit;
    end
  end

  // Sender: one message, then on a one-way link the extra copies one
  // tick apart; a retry count of zero is treated as one send.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      snd_q       <= TAM_IDLE;
      cur_q       <= '0;
      left_q      <= REP_ZERO;
      msg_valid_o <= 1'b0;
      msg_src_o   <= '0;
      msg_id_o    <= ID_NONE;
    end else begin
      msg_valid_o <= 1'b0;
      unique case (snd_q)
        TAM_IDLE: begin
          if (any_pend) begin
            cur_q  <= pick;
            left_q <= (oneway_i && retry_i > REP_ONE)
                      ? retry_i : REP_ONE;
            snd_q  <= TAM_SEND;
          end
        end
        TAM_SEND: begin
          msg_valid_o <= 1'b1;
          msg_src_o   <= cur_q;
          msg_id_o    <= station_id_i;
          left_q      <= left_q - REP_ONE;
          snd_q       <= (left_q == REP_ONE) ? TAM_IDLE : TAM_GAP;
        end
        TAM_GAP: begin
          if (tick_q) begin
            snd_q <= TAM_SEND;
          end
        end
        default: begin
          snd_q <= TAM_IDLE;
        end
      endcase
    end
  end

  // An outstation answers only a poll naming its own, non-zero ID.
  assign addressed = rx_valid_i && rx_poll_i &&
                     (rx_id_i == station_id_i) && (rx_id_i != ID_NONE);

  // Mirroring, polling and port routing by station role.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      tx_state_vld_o <= 1'b0;
      tx_din_o       <= 4'h0;
      poll_vld_o     <= 1'b0;
      poll_id_o      <= ID_NONE;
      dout_o         <= 4'h0;
      main_vld_o     <= 1'b0;
      main_data_o    <= 8'h00;
      sec_vld_o      <= 1'b0;
      sec_data_o     <= 8'h00;
      sec_div_o      <= SEC_DIV;
      alarm_o        <= 8'h00;
      tick_o         <= 1'b0;
    end else begin
      alarm_o        <= alarm_q;
      tick_o         <= tick_q;
      tx_din_o       <= din_i;
      sec_div_o      <= SEC_DIV;
      tx_state_vld_o <= 1'b0;
      poll_vld_o     <= 1'b0;
      main_vld_o     <= 1'b0;
      sec_vld_o      <= 1'b0;
      unique case (mode_i)
        TAM_ONE_WAY_MIRROR_OUTSTATION: begin
          tx_state_vld_o <= din_i != din_q;
        end
        TAM_TWO_WAY_MIRROR_MASTER, TAM_TWO_WAY_MIRROR_OUTSTATION: begin
          tx_state_vld_o <= din_i != din_q;
          if (rx_valid_i && !rx_poll_i) begin
            dout_o <= rx_din_i;
          end
        end
        TAM_ONE_WAY_MIRROR_MASTER: begin
          if (rx_valid_i && !rx_poll_i) begin
            dout_o <= rx_din_i;
          end
        end
        TAM_MULTI_OUTSTATION, TAM_COMBINED_OUTSTATION: begin
          tx_state_vld_o <= addressed;
        end
        TAM_MULTI_OUTSTATION_MASTER, TAM_COMBINED_POLLED_MASTER: begin
          if (poll_req_i && poll_id_i != ID_NONE) begin
            poll_vld_o <= 1'b1;
            poll_id_o  <= poll_id_i;
          end
          if (rx_valid_i && !rx_poll_i && mode_i[1]) begin
            main_vld_o  <= rx_data_vld_i;
            main_data_o <= rx_data_i;
            sec_vld_o   <= !rx_data_vld_i || rx_alarm_i;
            sec_data_o  <= rx_alarm_i ? rx_data_i : {4'h0, rx_din_i};
          end
        end
      endcase
    end
  end

  property p_thr_zero;
    @(posedge clk_i) disable iff (!rst_n_i)
    (ain_thr_i[0] == 10'h000) [*3] |-> !alarm_q[0];
  endproperty
  a_thr_zero: assert property (p_thr_zero)
    else $error("Analogue alarm raised with a zero threshold.");
  property p_tick_period;
    @(posedge clk_i) disable iff (!rst_n_i)
    tick_q |=> !tick_q [*2];
  endproperty
  a_tick_period: assert property (p_tick_period)
    else $error("Timing tick came too soon.");
  sequence s_onset;
    rise != '0;
  endsequence
  property p_onset_queued;
    @(posedge clk_i) disable iff (!rst_n_i)
    s_onset |=> (pend_q & $past(rise)) == $past(rise);
  endproperty
  a_onset_queued: assert property (p_onset_queued)
    else $error("Alarm onset did not queue a message.");
  property p_no_repeat;
    @(posedge clk_i) disable iff (!rst_n_i)
    (repeat_i == REP_ZERO && rise == '0) |=> (pend_q & ~$past(pend_q)) == '0;
  endproperty
  a_no_repeat: assert property (p_no_repeat)
    else $error("Message repeated with a zero interval.");
  property p_single_send;
    @(posedge clk_i) disable iff (!rst_n_i)
    (snd_q == TAM_SEND && left_q == REP_ONE) |=> snd_q == TAM_IDLE;
  endproperty
  a_single_send: assert property (p_single_send)
    else $error("Extra alarm copy sent after the last retry.");
  property p_mirror_copy;
    @(posedge clk_i) disable iff (!rst_n_i)
    (mode_i == TAM_ONE_WAY_MIRROR_MASTER && rx_valid_i && !rx_poll_i)
      |=> dout_o == $past(rx_din_i);
  endproperty
  a_mirror_copy: assert property (p_mirror_copy)
    else $error("Master outputs do not mirror the outstation inputs.");
  sequence s_foreign_poll;
    mode_i == TAM_MULTI_OUTSTATION && rx_id_i != station_id_i;
  endsequence
  property p_only_own_id;
    @(posedge clk_i) disable iff (!rst_n_i)
    s_foreign_poll |=> !tx_state_vld_o;
  endproperty
  a_only_own_id: assert property (p_only_own_id)
    else $error("Outstation answered a poll for another ID.");
  property p_sec_alarm;
    @(posedge clk_i) disable iff (!rst_n_i)
    (mode_i == TAM_COMBINED_POLLED_MASTER && rx_valid_i && !rx_poll_i &&
     rx_alarm_i) |=> sec_vld_o && !main_vld_o == !$past(rx_data_vld_i);
  endproperty
  a_sec_alarm: assert property (p_sec_alarm)
    else $error("Alarm frame not routed to the secondary port.");
endmodule

// file: testbench/tam_remote.sv
`timescale 1ns/1ps
// Far-side station model: frames arrive as one-cycle strobes on the link.
module tam_remote (
  input  wire logic       clk_i,        // System clock.
  output logic            rx_valid_o,   // Frame strobe.
  output logic            rx_poll_o,    // Frame is a poll.
  output logic [7:0]      rx_id_o,      // Frame ID.
  output logic [3:0]      rx_din_o,     // Remote input states.
  output logic            rx_alarm_o,   // Frame carries an alarm.
  output logic [7:0]      rx_data_o,    // Frame payload.
  output logic            rx_data_vld_o // Payload is user data.
);
  // Lines start idle so nothing is taken before the first frame.
  initial begin
    rx_valid_o = 1'b0;
    rx_poll_o = 1'b0;
    rx_id_o = 8'h00;
    rx_din_o = 4'h0;
    rx_alarm_o = 1'b0;
    rx_data_o = 8'h00;
    rx_data_vld_o = 1'b0;
  end

  // One frame per call; afterwards the lines carry inverted junk, so a
  // stale frame field can never pass for a fresh one.
  task automatic send(input logic poll, input logic [7:0] id,
                      input logic [3:0] din, input logic alarm,
                      input logic [7:0] data, input logic dvld);
    @(negedge clk_i);
    rx_valid_o = 1'b1;
    rx_poll_o = poll;
    rx_id_o = id;
    rx_din_o = din;
    rx_alarm_o = alarm;
    rx_data_o = data;
    rx_data_vld_o = dvld;
    @(negedge clk_i);
    rx_valid_o = 1'b0;
    rx_poll_o = ~poll;
    rx_id_o = ~id;
    rx_din_o = ~din;
    rx_alarm_o = ~alarm;
    rx_data_o = ~data;
    rx_data_vld_o = ~dvld;
  endtask
endmodule

// file: testbench/tb.sv
`timescale 1ns/1ps
module tb;
  import tam_pkg::*;
  localparam int T = 10;
  logic                 clk_i = 1'b0;
  logic                 rst_n_i = 1'b0;
  tam_mode_t            mode_i;
  logic [7:0]           station_id_i, poll_id_i, msg_id_o, poll_id_o;
  logic                 oneway_i, poll_req_i, rx_valid_i, rx_poll_i;
  logic [3:0][9:0]      ain_value_i, ain_thr_i;
  logic [3:0]           ain_below_i, din_i, din_en_i, din_fall_i;
  logic [7:0][7:0]      val_period_i;
  logic [9:0]           repeat_i, retry_i;
  logic [7:0]           rx_id_i, rx_data_i, alarm_o, main_data_o;
  logic [3:0]           rx_din_i, tx_din_o, dout_o;
  logic                 rx_alarm_i, rx_data_vld_i, msg_valid_o;
  logic                 tx_state_vld_o, poll_vld_o, main_vld_o;
  logic                 sec_vld_o, tick_o;
  logic [2:0]           msg_src_o;
  logic [7:0]           sec_data_o, last_id;
  logic [11:0]          sec_div_o;
  logic [31:0]          seed = 32'h0000_E8AD;
  logic [2:0]           srcq[$];
  int                   n_msg, num_errors, tests_run, n;
  logic [3:0]           d;
  logic [7:0]           d8;

  tam_monitor #(.TICK_CYC(T)) u_dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .mode_i(mode_i),
    .station_id_i(station_id_i), .oneway_i(oneway_i),
    .ain_value_i(ain_value_i), .ain_thr_i(ain_thr_i),
    .ain_below_i(ain_below_i), .din_i(din_i), .din_en_i(din_en_i),
    .din_fall_i(din_fall_i), .val_period_i(val_period_i),
    .repeat_i(repeat_i), .retry_i(retry_i), .poll_req_i(poll_req_i),
    .poll_id_i(poll_id_i), .rx_valid_i(rx_valid_i),
    .rx_poll_i(rx_poll_i), .rx_id_i(rx_id_i), .rx_din_i(rx_din_i),
    .rx_alarm_i(rx_alarm_i), .rx_data_i(rx_data_i),
    .rx_data_vld_i(rx_data_vld_i), .alarm_o(alarm_o),
    .msg_valid_o(msg_valid_o), .msg_src_o(msg_src_o),
    .msg_id_o(msg_id_o), .tx_state_vld_o(tx_state_vld_o),
    .tx_din_o(tx_din_o), .poll_vld_o(poll_vld_o),
    .poll_id_o(poll_id_o), .dout_o(dout_o), .main_vld_o(main_vld_o),
    .main_data_o(main_data_o), .sec_vld_o(sec_vld_o),
    .sec_data_o(sec_data_o), .sec_div_o(sec_div_o), .tick_o(tick_o));

  tam_remote u_rem (
    .clk_i(clk_i), .rx_valid_o(rx_valid_i), .rx_poll_o(rx_poll_i),
    .rx_id_o(rx_id_i), .rx_din_o(rx_din_i), .rx_alarm_o(rx_alarm_i),
    .rx_data_o(rx_data_i), .rx_data_vld_o(rx_data_vld_i));

  // Free-running 50 MHz system clock.
  always #10 clk_i = ~clk_i;

  // Record every alarm message; counts are judged against expected values later.
  always @(negedge clk_i) begin
    if (msg_valid_o === 1'b1) begin
      n_msg++;
      srcq.push_back(msg_src_o);
      last_id = msg_id_o;
    end
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic sig(input int s);
    case (s)
      0: return tx_state_vld_o;
      1: return poll_vld_o;
      2: return main_vld_o;
      3: return sec_vld_o;
      4: return tick_o;
      default: return alarm_o[3'(s-8)];
    endcase
  endfunction

  task automatic stop_test();
    $display("errors %0d, checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %0h, want %0h", $time, got, exp);
    end
  endtask

  // Waits are bounded; running out of cycles ends the run as a failure.
  task automatic wait_sig(input int s, input int lim, output int c);
    c = 0;
    while (sig(s) !== 1'b1) begin
      @(negedge clk_i);
      c++;
      if (c > lim) begin
        num_errors++;
        $display("unexpected at %0t: wait %0d timed out", $time, s);
        stop_test();
      end
    end
  endtask

  task automatic do_reset();
    mode_i = TAM_ONE_WAY_MIRROR_MASTER;
    station_id_i = 8'h05;
    {oneway_i, poll_req_i, poll_id_i} = '0;
    {ain_value_i, ain_thr_i, ain_below_i} = '0;
    {din_i, din_en_i, din_fall_i} = '0;
    val_period_i = {8{8'h01}};
    repeat_i = 10'h000;
    retry_i = 10'h001;
    rst_n_i = 1'b0;
    repeat (2) @(negedge clk_i);
    rst_n_i = 1'b1;
    n_msg = 0;
    srcq.delete();
  endtask

  // One alarm on input 0, then count every message in a fixed window.
  task automatic msg_run(input logic [9:0] rp, input logic [9:0] rt,
                         input logic ow, input int ex);
    int c;
    do_reset();
    repeat_i = rp;
    retry_i = rt;
    oneway_i = ow;
    ain_thr_i[0] = 10'h100;
    val_period_i[0] = 8'h02;
    ain_value_i[0] = 10'h101;
    wait_sig(8, 4*T, c);
    repeat (208) @(negedge clk_i);
    chk(n_msg, ex);
    foreach (srcq[i]) chk(srcq[i], 0);
    chk(last_id, station_id_i);
  endtask

  initial begin
    do_reset();
    // Analogue above threshold; a zero threshold never alarms.
    ain_thr_i[0] = 10'h064;
    ain_value_i[0] = 10'h065;
    val_period_i[0] = 8'h03;
    ain_value_i[1] = 10'h3FF;
    wait_sig(8, 5*T, n);
    chk(n >= 2*T && n <= 3*T+4, 1);
    chk(alarm_o[1], 1'b0);
    ain_value_i[0] = 10'h064;
    repeat (3) @(negedge clk_i);
    chk(alarm_o[0], 1'b0);
    // Below threshold, with an early drop that restarts the count.
    ain_below_i[2] = 1'b1;
    ain_thr_i[2] = 10'h200;
    ain_value_i[2] = 10'h1FF;
    val_period_i[2] = 8'h04;
    repeat (2*T) @(negedge clk_i);
    ain_value_i[2] = 10'h200;
    @(negedge clk_i);
    ain_value_i[2] = 10'h1FF;
    wait_sig(10, 6*T, n);
    chk(n >= 3*T && n <= 4*T+4, 1);
    // Digital: bit 0 rises, bit 1 rises but is disabled, bit 2 falls.
    din_en_i = 4'h5;
    din_fall_i = 4'h4;
    din_i = 4'h4;
    val_period_i[4] = 8'h02;
    val_period_i[6] = 8'h02;
    repeat (2) @(negedge clk_i);
    din_i = 4'h3;
    wait_sig(12, 4*T, n);
    wait_sig(14, 4*T, n);
    chk(alarm_o[5], 1'b0);
    // One message per onset, lowest pending input first.
    repeat (4) @(negedge clk_i);
    chk(srcq.size(), 4);
    chk({srcq[0], srcq[1], srcq[2], srcq[3]}, {3'h0, 3'h2, 3'h4, 3'h6});
    // Repeat, single send and one-way retries.
    msg_run(10'h005, 10'h001, 1'b0, 5);
    msg_run(10'h000, 10'h001, 1'b0, 1);
    msg_run(10'h000, 10'h003, 1'b1, 3);
    // One-way mirror master copies remote inputs; polls are ignored.
    do_reset();
    for (int k = 0; k < 4; k++) begin
      d = 4'(rnd() >> 7);
      u_rem.send(1'b0, 8'h05, d, 1'b0, 8'h00, 1'b0);
      @(negedge clk_i);
      chk(dout_o, d);
    end
    u_rem.send(1'b1, 8'h05, ~d, 1'b0, 8'h00, 1'b0);
    @(negedge clk_i);
    chk(dout_o, d);
    // Two-way mirror outstation sends its inputs and copies the remote.
    mode_i = TAM_TWO_WAY_MIRROR_OUTSTATION;
    repeat (3) @(negedge clk_i);
    din_i = din_i ^ (4'(rnd()) | 4'h1);
    wait_sig(0, 4, n);
    chk(tx_din_o, din_i);
    d = 4'(rnd() >> 3);
    u_rem.send(1'b0, 8'h05, d, 1'b0, 8'h00, 1'b0);
    @(negedge clk_i);
    chk(dout_o, d);
    // Polled outstations answer their own ID and ignore any other.
    for (int k = 0; k < 2; k++) begin
      mode_i = k ? TAM_COMBINED_OUTSTATION : TAM_MULTI_OUTSTATION;
      u_rem.send(1'b1, 8'h05, 4'h0, 1'b0, 8'h00, 1'b0);
      chk(tx_state_vld_o, 1'b1);
      u_rem.send(1'b1, 8'h06, 4'h0, 1'b0, 8'h00, 1'b0);
      chk(tx_state_vld_o, 1'b0);
    end
    // One-way outstation sends its inputs; two-way master copies.
    mode_i = TAM_ONE_WAY_MIRROR_OUTSTATION;
    din_i = ~din_i;
    @(negedge clk_i);
    chk(tx_state_vld_o, 1'b1);
    mode_i = TAM_TWO_WAY_MIRROR_MASTER;
    u_rem.send(1'b0, 8'h05, ~d, 1'b0, 8'h00, 1'b0);
    @(negedge clk_i);
    chk(dout_o, 4'(~d));
    // Multi-outstation master polls the highest outstation number.
    mode_i = TAM_MULTI_OUTSTATION_MASTER;
    poll_id_i = 8'hFF;
    poll_req_i = 1'b1;
    @(negedge clk_i);
    poll_req_i = 1'b0;
    wait_sig(1, 4, n);
    chk(poll_id_o, 8'hFF);
    // Combined master splits user data from input and alarm data.
    mode_i = TAM_COMBINED_POLLED_MASTER;
    @(negedge clk_i);
    chk(sec_div_o, 12'hA2C);
    d8 = 8'(rnd());
    u_rem.send(1'b0, 8'h05, 4'h0, 1'b0, d8, 1'b1);
    wait_sig(2, 3, n);
    chk(main_data_o, d8);
    u_rem.send(1'b0, 8'h05, d, 1'b0, d8, 1'b0);
    wait_sig(3, 3, n);
    chk(sec_data_o, {4'h0, d});
    u_rem.send(1'b0, 8'h05, d, 1'b1, ~d8, 1'b0);
    wait_sig(3, 3, n);
    chk(sec_data_o, 8'(~d8));
    // Tick spacing sets every time base.
    wait_sig(4, 2*T, n);
    @(negedge clk_i);
    wait_sig(4, 2*T, n);
    chk(n, T-1);
    stop_test();
  end
endmodule
